// [inc/uamc_pkg.sv]
// Purpose: Shared constants and types for the serial port mode control block
// Assumes: 32-bit APB, one mode register, one port-side register and one read-only status register
// Notes: Offsets are byte addresses
package uamc_pkg;
    localparam logic [7:0] UAMC_MODE_OFS = 8'h00;
    localparam logic [7:0] UAMC_PORT_OFS = 8'h04;
    localparam logic [7:0] UAMC_STAT_OFS = 8'h08;
    localparam logic [31:0] UAMC_MODE_RST = 32'h0000_0000;
    localparam logic [31:0] UAMC_MODE_MASK = 32'h0000_BBFF;
    localparam logic [31:0] UAMC_PORT_MASK = 32'h0000_0FFF;
    localparam int UAMC_EN_BIT = 15;
    localparam int UAMC_HALT_WHEN_IDLE_BIT = 13;
    localparam int UAMC_IR_BIT = 12;
    localparam int UAMC_REQUEST_PIN_MODE_SELECT_BIT = 11;
    localparam int UAMC_UEN_LSB = 8;
    localparam int UAMC_WAKE_BIT = 7;
    localparam int UAMC_LOOP_BIT = 6;
    localparam int UAMC_AUTO_RATE_DETECT_BIT = 5;
    localparam int UAMC_RECEIVE_POLARITY_INVERT_BIT = 4;
    localparam int UAMC_HIGH_SPEED_RATE_SELECT_BIT = 3;
    localparam int UAMC_PDSEL_LSB = 1;
    localparam int UAMC_STOP_BIT_SELECT_BIT = 0;
    localparam int UAMC_PIN_N = 4;

    typedef enum logic [1:0] {
        UAMC_USE_TXRX = 2'b00,
        UAMC_USE_RTS = 2'b01,
        UAMC_USE_FLOW = 2'b10,
        UAMC_USE_BCLK = 2'b11
    } uamc_usage_e;

    typedef struct packed {
        logic portEnable;
        logic haltWhenIdle;
        logic infraredCodecEnable;
        logic requestPinModeSelect;
        uamc_usage_e pinUsageSelect;
        logic wakeEnable;
        logic internalLoopSelect;
        logic autoRateDetect;
        logic receivePolarityInvert;
        logic highSpeedRateSelect;
        logic [1:0] parityWidthSelect;
        logic stopBitSelect;
    } uamc_mode_s;

    // Pin order: 0 tx, 1 rts, 2 bclk, 3 cts
    typedef struct packed {
        logic [UAMC_PIN_N-1:0] owned;
    } uamc_own_s;
endpackage

// [verilog/uamc_pin_own.sv]
// Purpose: Decide which serial pins the port owns
// Assumes: Mode settings are registered
// Notes: Pure decode
`timescale 1ns/1ps
module uamc_pin_own
    import uamc_pkg::*;
(
    input wire uamc_mode_s mode,
    input wire logic txEnable,
    output uamc_own_s own
);
    always_comb begin
        own.owned = '0;
        if (mode.portEnable) begin
            own.owned[0] = txEnable;
            unique case (mode.pinUsageSelect)
                UAMC_USE_BCLK: own.owned[2] = 1'b1;
                UAMC_USE_FLOW: own.owned[3:1] = 3'b101;
                UAMC_USE_RTS: own.owned[1] = 1'b1;
                UAMC_USE_TXRX: own.owned[3:1] = 3'b000;
            endcase
        end
    end
endmodule // uamc_pin_own

// [verilog/uamc_pin_mux.sv]
// Purpose: Per-pin choice between serial port and general port latch
// Assumes: Output enables are active low
// Notes: One generate loop over the pins
`timescale 1ns/1ps
module uamc_pin_mux
    import uamc_pkg::*;
#(
    parameter int N = UAMC_PIN_N
) (
    input wire logic [N-1:0] owned,
    input wire logic [N-1:0] portOut,
    input wire logic [N-1:0] portDriveN,
    input wire logic [N-1:0] latchOut,
    input wire logic [N-1:0] dirIn,
    output logic [N-1:0] pinOut,
    output logic [N-1:0] pinOeN
);
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_pin
            // Direction register bit 1 means input, so enable is held off
            assign pinOut[i] = owned[i] ? portOut[i] : latchOut[i];
            assign pinOeN[i] = owned[i] ? portDriveN[i] : dirIn[i];
        end
    endgenerate
endmodule // uamc_pin_mux

// [verilog/uamc_mode_ctrl.sv]
// Purpose: Mode register and pin/path control of one serial port
// Assumes: APB slave, zero wait states; inputs synchronous to clk
// Notes: Serializer itself sits outside; this block steers it
`timescale 1ns/1ps
module uamc_mode_ctrl
    import uamc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic transmitEnable,
    input wire logic deviceIdle,
    input wire logic deviceSleep,
    input wire logic serTxData,
    input wire logic serRtsN,
    input wire logic serBclk,
    output logic serRxData,
    output logic serCtsN,
    output logic serRun,
    output logic infraredActive,
    output logic rtsSimplex,
    output logic autoRateDetect,
    output logic receivePolarityInvert,
    output logic highSpeedRateSelect,
    output logic [1:0] parityWidthSelect,
    output logic stopBitSelect,
    output logic wakeRequest,
    input wire logic receivePinIn,
    input wire logic clearToSendPinIn,
    output logic [UAMC_PIN_N-1:0] pinOut,
    output logic [UAMC_PIN_N-1:0] pinOeN
);
    typedef struct packed {
        uamc_mode_s mode;
        logic [11:0] portCfg;
        logic wake;
        logic [31:0] rdata;
    } uamc_state_s;

    uamc_state_s st_r;
    uamc_state_s st_nxt;
    uamc_own_s own;
    logic [UAMC_PIN_N-1:0] portOut;
    logic [UAMC_PIN_N-1:0] portDriveN;
    logic rxLine;
    logic irRx;
    logic irTx;
    logic wrEn;
    logic rdEn;
    logic hit;
    logic [31:0] modeWord;
    logic [31:0] statWord;

    uamc_pin_own uamc_pin_own_inst (
        .mode(st_r.mode),
        .txEnable(transmitEnable),
        .own(own)
    );

    // portCfg: [3:0] latch, [7:4] direction, [11:8] read back unused
    uamc_pin_mux #(.N(UAMC_PIN_N)) uamc_pin_mux_inst (
        .owned(own.owned),
        .portOut(portOut),
        .portDriveN(portDriveN),
        .latchOut(st_r.portCfg[3:0]),
        .dirIn(st_r.portCfg[7:4]),
        .pinOut(pinOut),
        .pinOeN(pinOeN)
    );

    // Port's own drive to its pins; rts and bclk pass through, not gated by run state
    always_comb begin
        irTx = ~serTxData; // Simple inverted pulse shaping stands in for codec
        portOut[0] = st_r.mode.infraredCodecEnable ? irTx : serTxData;
        portOut[1] = serRtsN;
        portOut[2] = serBclk;
        portOut[3] = 1'b1;
        // Owned tx, rts and bclk drive; cts is an input, never driven
        portDriveN = 4'h8;
    end

    // Receive path: loopback, infrared decode, idle halt
    always_comb begin
        irRx = ~receivePinIn;
        rxLine = st_r.mode.infraredCodecEnable ? irRx : receivePinIn;
        if (st_r.mode.internalLoopSelect) begin
            rxLine = serTxData;
        end
        serRun = st_r.mode.portEnable
            & ~(st_r.mode.haltWhenIdle & deviceIdle);
        // Disabled port sees an idle line so nothing toggles inside
        serRxData = serRun ? rxLine : 1'b1;
        serCtsN = own.owned[3] ? clearToSendPinIn : 1'b0;
    end

    assign infraredActive = st_r.mode.infraredCodecEnable;
    assign rtsSimplex = st_r.mode.requestPinModeSelect;
    assign autoRateDetect = st_r.mode.autoRateDetect;
    assign receivePolarityInvert = st_r.mode.receivePolarityInvert;
    assign highSpeedRateSelect = st_r.mode.highSpeedRateSelect;
    assign parityWidthSelect = st_r.mode.parityWidthSelect;
    assign stopBitSelect = st_r.mode.stopBitSelect;
    assign wakeRequest = st_r.wake;

    assign wrEn = psel & penable & pwrite;
    assign rdEn = psel & ~penable & ~pwrite;
    assign hit = (paddr == UAMC_MODE_OFS) | (paddr == UAMC_PORT_OFS)
        | (paddr == UAMC_STAT_OFS);
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~hit;
    assign prdata = st_r.rdata;

    always_comb begin
        modeWord = 32'h0000_0000;
        modeWord[UAMC_EN_BIT] = st_r.mode.portEnable;
        modeWord[UAMC_HALT_WHEN_IDLE_BIT] = st_r.mode.haltWhenIdle;
        modeWord[UAMC_IR_BIT] = st_r.mode.infraredCodecEnable;
        modeWord[UAMC_REQUEST_PIN_MODE_SELECT_BIT] = st_r.mode.requestPinModeSelect;
        modeWord[UAMC_UEN_LSB +: 2] = st_r.mode.pinUsageSelect;
        modeWord[UAMC_WAKE_BIT] = st_r.mode.wakeEnable;
        modeWord[UAMC_LOOP_BIT] = st_r.mode.internalLoopSelect;
        modeWord[UAMC_AUTO_RATE_DETECT_BIT] = st_r.mode.autoRateDetect;
        modeWord[UAMC_RECEIVE_POLARITY_INVERT_BIT] = st_r.mode.receivePolarityInvert;
        modeWord[UAMC_HIGH_SPEED_RATE_SELECT_BIT] = st_r.mode.highSpeedRateSelect;
        modeWord[UAMC_PDSEL_LSB +: 2] = st_r.mode.parityWidthSelect;
        modeWord[UAMC_STOP_BIT_SELECT_BIT] = st_r.mode.stopBitSelect;
        modeWord = modeWord & UAMC_MODE_MASK;
        statWord = {26'h000_0000, st_r.wake, serRun, own.owned};
    end

    always_comb begin
        st_nxt = st_r;
        // Sleep wake on low receive line; held until sleep ends or wakeEnable clears
        if (st_r.mode.portEnable & st_r.mode.wakeEnable & deviceSleep
            & ~receivePinIn) begin
            st_nxt.wake = 1'b1;
        end else if (~deviceSleep) begin
            st_nxt.wake = 1'b0;
        end
        if (~st_r.mode.wakeEnable) begin
            st_nxt.wake = 1'b0;
        end
        if (rdEn) begin
            st_nxt.rdata = (paddr == UAMC_MODE_OFS) ? modeWord
                : (paddr == UAMC_PORT_OFS)
                ? ({20'h0_0000, st_r.portCfg} & UAMC_PORT_MASK)
                : (paddr == UAMC_STAT_OFS) ? statWord : 32'h0000_0000;
        end
        if (wrEn && paddr == UAMC_MODE_OFS) begin
            st_nxt.mode.portEnable = pwdata[UAMC_EN_BIT];
            st_nxt.mode.haltWhenIdle = pwdata[UAMC_HALT_WHEN_IDLE_BIT];
            st_nxt.mode.infraredCodecEnable = pwdata[UAMC_IR_BIT];
            st_nxt.mode.requestPinModeSelect = pwdata[UAMC_REQUEST_PIN_MODE_SELECT_BIT];
            st_nxt.mode.pinUsageSelect =
                uamc_usage_e'(pwdata[UAMC_UEN_LSB +: 2]);
            st_nxt.mode.wakeEnable = pwdata[UAMC_WAKE_BIT];
            st_nxt.mode.internalLoopSelect = pwdata[UAMC_LOOP_BIT];
            st_nxt.mode.autoRateDetect = pwdata[UAMC_AUTO_RATE_DETECT_BIT];
            st_nxt.mode.receivePolarityInvert = pwdata[UAMC_RECEIVE_POLARITY_INVERT_BIT];
            st_nxt.mode.highSpeedRateSelect = pwdata[UAMC_HIGH_SPEED_RATE_SELECT_BIT];
            st_nxt.mode.parityWidthSelect = pwdata[UAMC_PDSEL_LSB +: 2];
            st_nxt.mode.stopBitSelect = pwdata[UAMC_STOP_BIT_SELECT_BIT];
        end
        if (wrEn && paddr == UAMC_PORT_OFS) begin
            st_nxt.portCfg = pwdata[11:0];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r.mode <= '0;
            // Direction bits reset to input so pins float until set
            st_r.portCfg <= 12'h0F0;
            st_r.wake <= 1'b0;
            st_r.rdata <= 32'h0000_0000;
        end else begin
            st_r <= st_nxt;
        end
    end
endmodule // uamc_mode_ctrl

// [bench/uamc_mode_ctrl_checker.sv]
// Purpose: Port checks for the serial mode control block
// Assumes: One clock, async active-high reset
// Notes: Bound onto the block after the module
`timescale 1ns/1ps
module uamc_mode_ctrl_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic transmitEnable,
    input wire logic deviceIdle,
    input wire logic deviceSleep,
    input wire logic serTxData,
    input wire logic serRxData,
    input wire logic serRun,
    input wire logic infraredActive,
    input wire logic rtsSimplex,
    input wire logic wakeRequest,
    input wire logic receivePinIn,
    input wire logic [3:0] pinOut,
    input wire logic [3:0] pinOeN
);
    logic [31:0] wrD;
    logic wrQ;
    always_ff @(posedge clk) begin
        wrD <= pwdata;
        wrQ <= psel && penable && pwrite && paddr == 8'h00;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_rd; psel && penable && !pwrite && paddr == 8'h00; endsequence
    sequence s_wr; psel && penable && pwrite && paddr == 8'h00; endsequence
    chk_rd_reserved:
    assert property (s_rd |-> (prdata & 32'hFFFF_4400) == 32'h0000_0000)
        else $error("reserved mode bits set");
    chk_rd_fields:
    assert property (s_rd |-> prdata[12] == infraredActive
        && prdata[11] == rtsSimplex) else $error("mode read mismatch");
    chk_wr_fields:
    assert property (s_wr |=> infraredActive == wrD[12]
        && rtsSimplex == wrD[11]) else $error("mode write lost");
    chk_run_cause:
    assert property ($changed(serRun) |-> wrQ || $changed(deviceIdle))
        else $error("run changed without cause");
    chk_tx_owned:
    assert property (serRun && transmitEnable |-> !pinOeN[0]
        && pinOut[0] == (serTxData ^ infraredActive))
        else $error("tx pin not driven");
    chk_rx_idle:
    assert property (!serRun |-> serRxData) else $error("rx not idle");
    chk_wake_cause:
    assert property ($rose(wakeRequest) |-> $past(deviceSleep)
        && !$past(receivePinIn)) else $error("wake without start");
    chk_wake_sleep:
    assert property (wakeRequest |-> $past(deviceSleep))
        else $error("wake outside sleep");
endmodule // uamc_mode_ctrl_checker
bind uamc_mode_ctrl uamc_mode_ctrl_checker uamc_mode_ctrl_checker_inst (
    .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .transmitEnable, .deviceIdle, .deviceSleep, .serTxData, .serRxData,
    .serRun, .infraredActive, .rtsSimplex, .wakeRequest, .receivePinIn,
    .pinOut, .pinOeN);

// [bench/uamc_remote.sv]
// Purpose: Remote serial device facing the port pins
// Assumes: Bench clock
// Notes: Stall holds off flow control to model a slow peer
`timescale 1ns/1ps
module uamc_remote (
    input wire logic clk,
    input wire logic sendStart,
    input wire logic stall,
    output logic rxLine,
    output logic ctsN
);
    logic startQ = 1'b0;
    always @(posedge clk) startQ <= sendStart;
    // Line rests at mark between frames; a start bit pulls it low
    assign rxLine = ~startQ;
    assign ctsN = stall;
endmodule // uamc_remote

// [bench/uamc_mode_ctrl_tb.sv]
// Purpose: Self-checking bench for the serial mode control block
// Assumes: Zero-wait APB slave
// Notes: Serializer side is driven directly
`timescale 1ns/1ps
`define CK(n, e, v) begin checks++; if ((v) !== (e)) begin n_fail++; \
    $display("unexpected %s exp %h got %h", n, e, v); end end
module uamc_mode_ctrl_tb
    import uamc_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic transmitEnable = 1'b0, deviceIdle = 1'b0, deviceSleep = 1'b0;
    logic serTxData = 1'b0, sendStart = 1'b0, stall = 1'b0, er;
    logic serRtsN = 1'b0, serBclk = 1'b0, autoRateDetect;
    logic receivePolarityInvert, highSpeedRateSelect, stopBitSelect;
    logic [1:0] parityWidthSelect;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, serRxData, serCtsN, serRun, infraredActive;
    logic rtsSimplex, wakeRequest, receivePinIn, clearToSendPinIn;
    logic [UAMC_PIN_N-1:0] pinOut, pinOeN;
    int n_fail = 0, checks = 0;
    always #2.5 clk = ~clk;
    uamc_mode_ctrl uamc_mode_ctrl_inst (
        .clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .transmitEnable, .deviceIdle, .deviceSleep,
        .serTxData, .serRtsN, .serBclk, .serRxData, .serCtsN,
        .serRun, .infraredActive, .rtsSimplex, .autoRateDetect,
        .receivePolarityInvert, .highSpeedRateSelect,
        .parityWidthSelect, .stopBitSelect, .wakeRequest,
        .receivePinIn, .clearToSendPinIn, .pinOut, .pinOeN);
    uamc_remote uamc_remote_inst (.clk, .sendStart, .stall,
        .rxLine(receivePinIn), .ctsN(clearToSendPinIn));
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge clk); // idle cycle before every setup
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic t_regs;
        apb(0, UAMC_MODE_OFS, 0);
        `CK("mode", UAMC_MODE_RST, rd)
        `CK("oe", 4'hF, pinOeN)
        apb(1, UAMC_MODE_OFS, 32'hFFFF_FFFF);
        apb(0, UAMC_MODE_OFS, 0);
        `CK("mode rw", 32'h0000_BBFF, rd)
        `CK("rts", 1'b1, rtsSimplex)
        `CK("low fields", 6'h3F, {autoRateDetect, receivePolarityInvert,
            highSpeedRateSelect, parityWidthSelect, stopBitSelect})
        apb(0, 8'h0C, 0);
        `CK("err", 1'b1, er)
        `CK("unmapped rd", 32'h0000_0000, rd)
        $display("t_regs done");
    endtask
    task automatic t_pins;
        logic [3:0] own;
        apb(1, UAMC_PORT_OFS, 32'h0000_00FF);
        transmitEnable <= 1'b1;
        for (int u = 0; u < 4; u++) begin
            apb(1, UAMC_MODE_OFS, 32'h0000_8000 | (32'(u) << 8));
            own = {u == 2, u == 3, u == 1 || u == 2, 1'b1};
            apb(0, UAMC_STAT_OFS, 0);
            `CK("owned", own, rd[3:0])
            `CK("pins", {2{1'b1, ~own[2:0]}}, {pinOut, pinOeN})
        end
        transmitEnable <= 1'b0;
        apb(1, UAMC_MODE_OFS, 0);
        apb(1, UAMC_PORT_OFS, 32'hFFFF_FA05);
        @(negedge clk);
        `CK("latch", 8'h50, {pinOut, pinOeN})
        apb(0, UAMC_PORT_OFS, 0);
        `CK("port rd", 32'h0000_0A05, rd)
        $display("t_pins done");
    endtask
    task automatic t_power;
        apb(1, UAMC_MODE_OFS, 32'h0000_A080);
        deviceIdle <= 1'b1;
        @(negedge clk);
        `CK("halt", 1'b0, serRun)
        apb(1, UAMC_MODE_OFS, 32'h0000_8080);
        deviceSleep <= 1'b1;
        sendStart <= 1'b1;
        @(negedge clk);
        `CK("run", 1'b1, serRun)
        for (int i = 0; i < 8 && wakeRequest !== 1'b1; i++) @(negedge clk);
        `CK("wake", 1'b1, wakeRequest)
        @(posedge clk);
        sendStart <= 1'b0;
        deviceSleep <= 1'b0;
        apb(1, UAMC_MODE_OFS, 32'h0000_8000);
        deviceSleep <= 1'b1;
        sendStart <= 1'b1;
        repeat (8) @(negedge clk);
        `CK("no wake", 1'b0, wakeRequest)
        @(posedge clk);
        sendStart <= 1'b0;
        deviceSleep <= 1'b0;
        deviceIdle <= 1'b0;
        $display("t_power done");
    endtask
    task automatic t_loop;
        apb(1, UAMC_MODE_OFS, 32'h0000_8040);
        for (int b = 0; b < 2; b++) begin
            @(posedge clk);
            serTxData <= b[0];
            @(negedge clk);
            `CK("loop", b[0], serRxData)
        end
        apb(1, UAMC_MODE_OFS, 32'h0000_9200);
        stall <= 1'b1;
        transmitEnable <= 1'b1;
        @(negedge clk);
        `CK("ir rx", 1'b0, serRxData)
        `CK("cts", 1'b1, serCtsN)
        `CK("ir tx", 1'b0, pinOut[0])
        apb(1, UAMC_MODE_OFS, 32'h0000_8100);
        serRtsN <= 1'b1;
        @(negedge clk);
        `CK("cts free", 1'b0, serCtsN)
        `CK("rts pin", 2'b01, {pinOeN[1], pinOut[1]})
        $display("t_loop done");
    endtask
    initial begin
        #20000;
        n_fail++;
        end_sim;
    end
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_pins;
        t_power;
        t_loop;
        end_sim;
    end
endmodule // uamc_mode_ctrl_tb
